//--- core/pefms_pkg.sv
// constants, field layouts and carriers for the pmic event flag, mask and sense block
// assumes a register port from the serial control block and analog comparator levels as inputs
//
// Behaviour
// - bank 0 flags: thermal at bits 5..2, undervolt bit 1, turn-on bit 0
// - each thermal flag sets when its threshold is crossed either way
// - writing 1 clears a flag, writing 0 leaves it alone
// - undervolt flag sets when input supply drops below 2.7 V
// - turn-on flag sets on a turn-on event
// - every flag has a same-position mask bit, 1 masks, 0 unmasks
// - unmasked latched flags show on the interrupt pin, masked ones do not
// - sense bank 0 at 0x07, read-only, bit 6 reads 0, bit 7 test pin
// - thermal sense bits 5..2 show live comparison, 1 above threshold
// - undervolt sense bit reads 1 while supply below 2.7 V
// - turn-on sense bit follows the live turn-on pin level
// - test-pin sense bit 7 reads 0 grounded, 1 at core supply
// - sense bits reset to 0 and follow the monitored inputs two clocks later, bit 6 resets to 0
// - bank 1 overcurrent flags at bits 4, 3, 0 set in current limit
// - bank 1 mask bits at 4, 3, 0, 1 masks, 0 unmasks
// - sense bank 1 bits follow live overcurrent of the three bucks
// - bank 1 sense bits read 1 above current limit, at 4, 3, 0

package pefms_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_FLAGS0 = 8'h05;
	localparam logic [7:0] OFS_MASKS0 = 8'h06;
	localparam logic [7:0] OFS_LIVE0 = 8'h07;
	localparam logic [7:0] OFS_FLAGS1 = 8'h08;
	localparam logic [7:0] OFS_MASKS1 = 8'h09;
	localparam logic [7:0] OFS_LIVE1 = 8'h0a;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_TURN_ON = 0;
	localparam int BIT_UNDERVOLT = 1;
	localparam int BIT_THERM_LO = 2;
	localparam int BIT_THERM_HI = 5;
	localparam int BIT_RESERVED = 6;
	localparam int BIT_TEST_PIN = 7;
	localparam int BIT_BUCK_A = 0;
	localparam int BIT_BUCK_B = 3;
	localparam int BIT_BUCK_C = 4;

	// implemented bits of each bank
	localparam logic [7:0] IMPL_FLAGS0 = 8'h3f;
	localparam logic [7:0] IMPL_FLAGS1 = 8'h19;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASKS0 = 8'h3f;
	localparam logic [7:0] RST_MASKS1 = 8'h19;
	localparam logic [7:0] RST_DATA = 8'h00;

	// cycles for the two-flop synchroniser to fill after reset
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic test_pin;
		logic [3:0] thermal; // hi3, hi2, hi1, lo
		logic undervolt;
		logic turn_on;
		logic [2:0] buck_oc; // c, b, a
	} pefms_cond_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pefms_req_s;

endpackage

//--- core/pefms_top.sv
// event flags, masks and live sense banks 0 and 1 with open-drain interrupt
// assumes the serial control block presents one-cycle register requests on clk
`timescale 1ns/1ps

module pefms_top (
	input wire logic clk,
	input wire logic rstn,
	input wire pefms_pkg::pefms_cond_s cond_in,
	input wire pefms_pkg::pefms_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic irq_out_n,
	output logic irq_oe_n
);
	import pefms_pkg::*;

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	pefms_cond_s sync1;
	pefms_cond_s live;
	pefms_cond_s prev;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic armed;

	pefms_cond_s next_sync1;
	pefms_cond_s next_live;
	pefms_cond_s next_prev;

	// only the second stage reads the first, so metastability stays inside the pair
	always_comb begin
		next_sync1 = cond_in;
		next_live = sync1;
		next_prev = live;
	end

	// analog comparators are asynchronous to clk
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1 <= '0;
			live <= '0;
			prev <= '0;
			settle <= '0;
		end else begin
			sync1 <= next_sync1;
			live <= next_live;
			prev <= next_prev;
			settle <= next_settle;
		end
	end

	// no edges are seen until the synchroniser holds real pin levels
	always_comb begin
		next_settle = settle;
		if (settle != SETTLE_CYCLES + 2'h1) begin
			next_settle = settle + 2'h1;
		end
	end
	assign armed = (settle == SETTLE_CYCLES + 2'h1);

	// ----------------------------------------
	// live sense banks
	// ----------------------------------------
	logic [7:0] live0;
	logic [7:0] live1;

	always_comb begin
		live0 = 8'h00; // bit 6 stays 0
		live0[BIT_TEST_PIN] = live.test_pin;
		live0[BIT_THERM_HI:BIT_THERM_LO] = live.thermal;
		live0[BIT_UNDERVOLT] = live.undervolt;
		live0[BIT_TURN_ON] = live.turn_on;
		live1 = 8'h00;
		live1[BIT_BUCK_C] = live.buck_oc[2];
		live1[BIT_BUCK_B] = live.buck_oc[1];
		live1[BIT_BUCK_A] = live.buck_oc[0];
	end

	// ----------------------------------------
	// event detection
	// ----------------------------------------
	logic [7:0] set0;
	logic [7:0] set1;

	always_comb begin
		set0 = 8'h00;
		set1 = 8'h00;
		if (armed) begin
			set0[BIT_THERM_HI:BIT_THERM_LO] = live.thermal ^ prev.thermal;
			set0[BIT_UNDERVOLT] = live.undervolt & ~prev.undervolt;
			set0[BIT_TURN_ON] = live.turn_on & ~prev.turn_on;
			// level set: a buck held in limit cannot be cleared away
			set1[BIT_BUCK_C] = live.buck_oc[2];
			set1[BIT_BUCK_B] = live.buck_oc[1];
			set1[BIT_BUCK_A] = live.buck_oc[0];
		end
	end

	// ----------------------------------------
	// flags, masks and register port
	// ----------------------------------------
	localparam int CELLS = 8;

	logic [7:0] event_flags_bank0;
	logic [7:0] event_flags_bank1;
	logic [7:0] event_masks_bank0;
	logic [7:0] event_masks_bank1;
	logic [7:0] clr0;
	logic [7:0] clr1;
	logic wr_masks0;
	logic wr_masks1;
	logic [7:0] next_masks0;
	logic [7:0] next_masks1;
	wire logic [7:0] next_flags0;
	wire logic [7:0] next_flags1;
	wire logic [7:0] pend0;
	wire logic [7:0] pend1;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic next_irq_n;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// sense banks and unmapped offsets fall to the default and are ignored
	always_comb begin
		clr0 = 8'h00;
		clr1 = 8'h00;
		wr_masks0 = 1'b0;
		wr_masks1 = 1'b0;
		if (req.wr) begin
			case (req.addr)
				OFS_FLAGS0: begin
					clr0 = req.wdata;
				end
				OFS_FLAGS1: begin
					clr1 = req.wdata;
				end
				OFS_MASKS0: begin
					wr_masks0 = 1'b1;
				end
				OFS_MASKS1: begin
					wr_masks1 = 1'b1;
				end
				default: begin
					clr0 = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------
	// per-bit flag cells
	// ----------------------------------------
	// unimplemented positions are tied low so they never latch or pend
	genvar gi;
	generate
		for (gi = 0; gi < CELLS; gi++) begin : g_cell
			// set wins over a clear in the same cycle so no event is lost
			assign next_flags0[gi] = IMPL_FLAGS0[gi] & (set0[gi] | (event_flags_bank0[gi] & ~clr0[gi]));
			assign next_flags1[gi] = IMPL_FLAGS1[gi] & (set1[gi] | (event_flags_bank1[gi] & ~clr1[gi]));
			// a flag reaches the pin only while its mask bit is 0
			assign pend0[gi] = event_flags_bank0[gi] & ~event_masks_bank0[gi];
			assign pend1[gi] = event_flags_bank1[gi] & ~event_masks_bank1[gi];
		end
	endgenerate

	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	// spare mask bits are dropped on write so they always read 0
	always_comb begin
		next_masks0 = event_masks_bank0;
		next_masks1 = event_masks_bank1;
		if (wr_masks0) begin
			next_masks0 = req.wdata & IMPL_FLAGS0;
		end
		if (wr_masks1) begin
			next_masks1 = req.wdata & IMPL_FLAGS1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			event_flags_bank0 <= RST_FLAGS;
			event_flags_bank1 <= RST_FLAGS;
			event_masks_bank0 <= RST_MASKS0;
			event_masks_bank1 <= RST_MASKS1;
		end else begin
			event_flags_bank0 <= next_flags0;
			event_flags_bank1 <= next_flags1;
			event_masks_bank0 <= next_masks0;
			event_masks_bank1 <= next_masks1;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// read returns the value before a write in the same cycle
	always_comb begin
		next_rvalid = req.rd;
		next_rdata = RST_DATA;
		if (req.rd) begin
			case (req.addr)
				OFS_FLAGS0: begin
					next_rdata = event_flags_bank0;
				end
				OFS_MASKS0: begin
					next_rdata = event_masks_bank0;
				end
				OFS_LIVE0: begin
					next_rdata = live0;
				end
				OFS_FLAGS1: begin
					next_rdata = event_flags_bank1;
				end
				OFS_MASKS1: begin
					next_rdata = event_masks_bank1;
				end
				OFS_LIVE1: begin
					next_rdata = live1;
				end
				default: begin
					next_rdata = RST_DATA;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= RST_DATA;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	// pin reflects latched, unmasked flags only
	always_comb begin
		next_irq_n = ~((|pend0) | (|pend1));
	end

	// one cycle behind the flags, traded for a glitch-free pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_out_n <= 1'b1;
			irq_oe_n <= 1'b1;
		end else begin
			// open drain: drive low only, enable low while driving
			irq_out_n <= next_irq_n;
			irq_oe_n <= next_irq_n;
		end
	end

endmodule // pefms_top

//--- test/pefms_checker.sv
// port-level checks of the event flag, mask and sense block
// sees only pefms_top ports; bound below
`timescale 1ns/1ps
module pefms_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire pefms_pkg::pefms_cond_s cond_in,
	input wire pefms_pkg::pefms_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic irq_out_n,
	input wire logic irq_oe_n
);
	import pefms_pkg::*;
	logic [2:0] age;
	pefms_cond_s q;
	// live bits only trusted once the synchroniser has held steady input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			age <= 3'h0;
			q <= '0;
		end else begin
			age <= !$stable(cond_in) ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
			q <= cond_in;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd(a); req.rd && req.addr == a; endsequence
	property p_ans; req.rd |=> rvalid; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_one; !req.rd |=> !rvalid; endproperty
	a_one: assert property (p_one) else $error("answer without read");
	property p_idle; !rvalid |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_pin; irq_oe_n == irq_out_n; endproperty
	a_pin: assert property (p_pin) else $error("pin enable and value differ");
	property p_live0; s_rd(OFS_LIVE0) ##0 age >= 3'h4 |=> rdata == {q[9], 1'b0, q[8:3]}; endproperty
	a_live0: assert property (p_live0) else $error("live bank 0 wrong");
	property p_live1; s_rd(OFS_LIVE1) ##0 age >= 3'h4 |=> rdata == {3'h0, q[2:1], 2'h0, q[0]}; endproperty
	a_live1: assert property (p_live1) else $error("live bank 1 wrong");
	property p_msk0; s_rd(OFS_MASKS0) |=> rdata[7:6] == 2'h0; endproperty
	a_msk0: assert property (p_msk0) else $error("mask bank 0 spare bits set");
	property p_msk1; s_rd(OFS_MASKS1) |=> (rdata & ~IMPL_FLAGS1) == 8'h00; endproperty
	a_msk1: assert property (p_msk1) else $error("mask bank 1 spare bits set");
endmodule // pefms_checker
bind pefms_top pefms_checker chk (.clk(clk), .rstn(rstn), .cond_in(cond_in), .req(req), .rdata(rdata),
	.rvalid(rvalid), .irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n));

//--- test/pefms_host.sv
// host model on the register port
// one request at a time, changed only just after a rising edge
`timescale 1ns/1ps
module pefms_host (
	input wire logic clk,
	input wire logic rvalid,
	input wire logic [7:0] rdata,
	output pefms_pkg::pefms_req_s req
);
	import pefms_pkg::*;
	initial req = '0;
	// callers pass exactly the ones to drop; zeros leave flags alone
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b0, 1'b1, a, d};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk) req <= '0;
		#1;
		for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(posedge clk) #1;
		d = rdata;
		if (n == 4) begin
			$display("[FAIL] %0t read not answered", $time);
			pefms_top_tb.error_cnt++;
			pefms_top_tb.test_done();
		end
	endtask
endmodule // pefms_host

//--- test/pefms_top_tb.sv
// self-checking bench for pefms_top
// host model drives requests, bench drives condition levels
`timescale 1ns/1ps
module pefms_top_tb;
	import pefms_pkg::*;
	logic clk, rstn, rvalid, irq_out_n, irq_oe_n;
	pefms_cond_s cond_in;
	pefms_req_s req;
	logic [7:0] rdata, d;
	int error_cnt = 0;
	int compares = 0;
	pefms_top uut (.clk(clk), .rstn(rstn), .cond_in(cond_in), .req(req), .rdata(rdata), .rvalid(rvalid),
		.irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n));
	pefms_host host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic t_reset();
		rchk(OFS_MASKS0, 8'h3f);
		rchk(OFS_MASKS1, 8'h19);
		rchk(OFS_FLAGS0, 8'h00);
		rchk(8'hff, 8'h00);
		host.wr(OFS_LIVE0, 8'hff);
		rchk(OFS_LIVE0, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_thermal();
		host.wr(OFS_MASKS0, 8'h00);
		@(posedge clk) cond_in.thermal <= 4'h8;
		repeat (5) @(posedge clk);
		#1 chk({7'h0, irq_out_n}, 8'h00);
		rchk(OFS_FLAGS0, 8'h20);
		rchk(OFS_LIVE0, 8'h20);
		host.wr(OFS_FLAGS0, 8'h00);
		rchk(OFS_FLAGS0, 8'h20);
		host.wr(OFS_FLAGS0, 8'h20);
		rchk(OFS_FLAGS0, 8'h00);
		chk({7'h0, irq_out_n}, 8'h01);
		@(posedge clk) cond_in.thermal <= 4'h0;
		repeat (5) @(posedge clk);
		rchk(OFS_FLAGS0, 8'h20);
		host.wr(OFS_FLAGS0, 8'h20);
		$display("thermal test done");
	endtask
	task automatic t_other();
		@(posedge clk) cond_in <= '{1'b1, 4'h0, 1'b1, 1'b1, 3'h7};
		repeat (5) @(posedge clk);
		rchk(OFS_FLAGS0, 8'h03);
		rchk(OFS_LIVE0, 8'h83);
		rchk(OFS_LIVE1, 8'h19);
		rchk(OFS_FLAGS1, 8'h19);
		host.wr(OFS_MASKS0, 8'h3f);
		rchk(OFS_MASKS0, 8'h3f);
		chk({7'h0, irq_out_n}, 8'h01);
		host.wr(OFS_MASKS1, 8'hff);
		rchk(OFS_MASKS1, 8'h19);
		host.wr(OFS_MASKS1, 8'h00);
		host.wr(OFS_FLAGS1, 8'h19);
		rchk(OFS_FLAGS1, 8'h19);
		chk({7'h0, irq_out_n}, 8'h00);
		$display("event test done");
	endtask
	task automatic test_done();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		cond_in = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_thermal();
		t_other();
		test_done();
	end
endmodule // pefms_top_tb
